// *** core/ltx_alu.sv ***
`timescale 1ns/10ps
`default_nettype none
// Operation
// - complement-mask test: flags from (not dst) and src
// - decode 62..66, lengths and cycle counts
// - mask test: flags from dst and src
// - decode 72..76, lengths and cycle counts
// - xor writes dst, source untouched
// - decode B2..B6, lengths and cycle counts
// - zero flag set when result zero
// - sign from bit 7, overflow cleared, carry kept
module ltx_alu
  import ltx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic issue, // one-cycle strobe: opcode and operands valid
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2, // second instruction byte
  input wire logic [7:0] byte3, // third instruction byte
  input wire logic [7:0] dst_val, // destination operand value
  input wire logic [7:0] src_val, // source operand value (register or pointed)
  input wire logic [3:0] flags_in, // current {c,z,s,v}
  output logic done, // one-cycle result strobe
  output logic hit, // opcode was one of ours
  output logic [7:0] result,
  output logic wr_en, // write result to destination
  output logic [7:0] dst_addr, // destination register address (byte2 or byte3 in long forms, high nibble of byte2 in short forms)
  output logic [7:0] src_addr, // source register address (byte2 or byte3 in long forms, low nibble of byte2 in short forms)
  output logic [3:0] flags_out, // updated {c,z,s,v}
  output logic [1:0] len, // instruction length in bytes
  output logic [2:0] cycles // instruction cycle count
);
  import ltx_pkg::*;

  ltx_op_t op; // decoded operation
  ltx_am_t amode; // decoded addressing form
  logic [1:0] len_d; // decoded length
  logic [2:0] cyc_d; // decoded cycle count
  logic [7:0] res_d; // combinational result
  logic [3:0] flg_d; // combinational flags
  logic [7:0] dsta_d; // combinational destination address
  logic [7:0] srca_d; // combinational source address

  ltx_decode u_dec (
    .opcode(opcode),
    .op(op),
    .amode(amode),
    .len(len_d),
    .cycles(cyc_d)
  );

  // datapath: tests only compute, xor computes and writes back
  always_comb begin
    unique case (op)
      LTX_OP_TCOMP: res_d = ~dst_val & src_val;
      LTX_OP_TMASK: res_d = dst_val & src_val;
      LTX_OP_XOR: res_d = dst_val ^ src_val;
      // not ours: never registered, so any value will do
      LTX_OP_NONE: res_d = dst_val;
    endcase
  end

  // flag update; carry always passes through untouched
  always_comb begin
    flg_d = flags_in;
    if (op != LTX_OP_NONE) begin
      flg_d[FLAG_Z] = (res_d == 8'h00);
      flg_d[FLAG_S] = res_d[SIGN_BIT];
      flg_d[FLAG_V] = 1'b0;
    end
  end

  // operand byte order: long register forms swap, short forms use nibbles of byte2
  always_comb begin
    if (amode == LTX_AM_GIM) begin
      dsta_d = byte2;
      srca_d = byte3;
    end else if (amode == LTX_AM_GG || amode == LTX_AM_GIR) begin
      srca_d = byte2;
      dsta_d = byte3;
    end else begin
      // working registers: dst high nibble, src low nibble
      dsta_d = {4'h0, byte2[7:4]};
      srca_d = {4'h0, byte2[3:0]};
    end
  end

  // completion strobe: every issue is answered exactly one cycle later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= issue;
    end
  end

  // hit strobe: unknown opcodes still answer, but as a miss
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hit <= 1'b0;
    end else begin
      hit <= issue && (op != LTX_OP_NONE);
    end
  end

  // write-back strobe: only xor writes; both tests leave operands alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_en <= 1'b0;
    end else begin
      wr_en <= issue && (op == LTX_OP_XOR);
    end
  end

  // result and flags held between hits, so the core may read them late
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result <= RESULT_RST;
      flags_out <= FLAGS_RST;
    end else if (issue && op != LTX_OP_NONE) begin
      result <= res_d;
      flags_out <= flg_d;
    end
  end

  // operand addresses; a miss leaves the last pair in place
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dst_addr <= ADDR_RST;
      src_addr <= ADDR_RST;
    end else if (issue && op != LTX_OP_NONE) begin
      dst_addr <= dsta_d;
      src_addr <= srca_d;
    end
  end

  // length and cycle count are reported, not waited out: the core sequences them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      len <= LEN_RST;
      cycles <= CYC_RST;
    end else if (issue && op != LTX_OP_NONE) begin
      len <= len_d;
      cycles <= cyc_d;
    end
  end

  // checks: strobes and reset
  reset_quiet_a: assert property (@(posedge core_clk)
    rst |=> !done && !hit && !wr_en)
    else $error("strobe high right after reset");
  done_follow_a: assert property (@(posedge core_clk) disable iff (rst)
    issue |=> done)
    else $error("issue not answered");
  done_single_a: assert property (@(posedge core_clk) disable iff (rst)
    !issue |=> !done)
    else $error("answer without an issue");
  hit_in_done_a: assert property (@(posedge core_clk) disable iff (rst)
    hit |-> done)
    else $error("hit outside an answer");
  write_in_hit_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_en |-> hit)
    else $error("write-back on a miss");

  // checks: results and flags
  zero_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    hit |-> flags_out[FLAG_Z] == (result == 8'h00))
    else $error("zero flag wrong");
  sign_ovf_a: assert property (@(posedge core_clk) disable iff (rst)
    hit |-> flags_out[FLAG_S] == result[SIGN_BIT] && !flags_out[FLAG_V])
    else $error("sign or overflow wrong");
  carry_kept_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && op != LTX_OP_NONE |=> flags_out[FLAG_C] == $past(flags_in[FLAG_C]))
    else $error("carry changed");
  tcomp_calc_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && op == LTX_OP_TCOMP |=> result == (~$past(dst_val) & $past(src_val)) && !wr_en)
    else $error("complement test result wrong");
  tmask_calc_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && op == LTX_OP_TMASK |=> result == ($past(dst_val) & $past(src_val)) && !wr_en)
    else $error("mask test result wrong");
  xor_write_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && op == LTX_OP_XOR |=> wr_en && result == ($past(dst_val) ^ $past(src_val)))
    else $error("xor result or write-back wrong");

  // checks: lengths, cycle counts and operand order
  tcomp_timing_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && opcode == OP_TCOMP_RR |=> len == LEN_SHORT && cycles == CYC_FAST)
    else $error("complement test short form timing wrong");
  tmask_timing_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && opcode == OP_TMASK_GIM |=> len == LEN_LONG && cycles == CYC_SLOW)
    else $error("mask test immediate timing wrong");
  xor_timing_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && opcode == OP_XOR_RIR |=> len == LEN_SHORT && cycles == CYC_SLOW)
    else $error("xor indirect timing wrong");
  short_fast_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && op != LTX_OP_NONE && opcode[3:0] == OP_XOR_RR[3:0] |=> len == LEN_SHORT && cycles == CYC_FAST)
    else $error("register pair timing wrong");
  long_form_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && op != LTX_OP_NONE && opcode[3:0] > 4'h3 |=> len == LEN_LONG && cycles == CYC_SLOW)
    else $error("three-byte form timing wrong");
  imm_order_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && opcode == OP_XOR_GIM |=> dst_addr == $past(byte2) && src_addr == $past(byte3))
    else $error("immediate form byte order wrong");
  reg_order_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && opcode == OP_TMASK_GG |=> dst_addr == $past(byte3) && src_addr == $past(byte2))
    else $error("register form byte order wrong");
  short_order_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && op != LTX_OP_NONE && opcode[3:0] < 4'h4
    |=> dst_addr == ($past(byte2) >> 4) && src_addr == ($past(byte2) & 8'h0F))
    else $error("working register split wrong");

  // checks: a miss leaves result, flags, dst_addr and len alone; an idle cycle leaves result, flags, src_addr, len and cycles alone
  miss_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    issue && op == LTX_OP_NONE
    |=> !hit && !wr_en && $stable(result) && $stable(flags_out) && $stable(dst_addr) && $stable(len))
    else $error("miss changed held outputs");
  idle_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !issue |=> $stable(result) && $stable(flags_out) && $stable(src_addr) && $stable(len) && $stable(cycles))
    else $error("idle cycle changed held outputs");

  // scenarios worth seeing at least once
  cov_tcomp_zero: cover property (@(posedge core_clk) issue && op == LTX_OP_TCOMP ##1 flags_out[FLAG_Z]);
  cov_tmask_hit: cover property (@(posedge core_clk) issue && op == LTX_OP_TMASK);
  cov_xor_wr: cover property (@(posedge core_clk) wr_en);
  cov_miss: cover property (@(posedge core_clk) done && !hit);
  cov_back2back: cover property (@(posedge core_clk) hit ##1 hit);
endmodule // ltx_alu
`default_nettype wire

// *** core/ltx_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
// combinational opcode decoder for the three logical instructions
module ltx_decode
  import ltx_pkg::*;
(
  input wire logic [7:0] opcode,
  output var ltx_pkg::ltx_op_t op,
  output var ltx_pkg::ltx_am_t amode,
  output logic [1:0] len,
  output logic [2:0] cycles
);
  import ltx_pkg::*;

  // high nibble picks the operation, low nibble the form
  always_comb begin
    unique case (opcode[7:4])
      OP_TCOMP_RR[7:4]: op = LTX_OP_TCOMP;
      OP_TMASK_RR[7:4]: op = LTX_OP_TMASK;
      OP_XOR_RR[7:4]: op = LTX_OP_XOR;
      default: op = LTX_OP_NONE;
    endcase
    amode = LTX_AM_RR;
    len = LEN_SHORT;
    cycles = CYC_FAST;
    // forms 2..6 of the low nibble; others are not ours
    unique case (opcode[3:0])
      OP_TCOMP_RR[3:0]: begin
        amode = LTX_AM_RR;
      end
      OP_TCOMP_RIR[3:0]: begin
        amode = LTX_AM_RIR;
        cycles = CYC_SLOW;
      end
      OP_TCOMP_GG[3:0]: begin
        amode = LTX_AM_GG;
        len = LEN_LONG;
        cycles = CYC_SLOW;
      end
      OP_TCOMP_GIR[3:0]: begin
        amode = LTX_AM_GIR;
        len = LEN_LONG;
        cycles = CYC_SLOW;
      end
      OP_TCOMP_GIM[3:0]: begin
        amode = LTX_AM_GIM;
        len = LEN_LONG;
        cycles = CYC_SLOW;
      end
      default: begin
        op = LTX_OP_NONE;
      end
    endcase
  end
endmodule // ltx_decode
`default_nettype wire

// *** core/ltx_pkg.sv ***
package ltx_pkg;
  // opcode encodings, complement-mask test
  localparam logic [7:0] OP_TCOMP_RR = 8'h62;
  localparam logic [7:0] OP_TCOMP_RIR = 8'h63;
  localparam logic [7:0] OP_TCOMP_GG = 8'h64;
  localparam logic [7:0] OP_TCOMP_GIR = 8'h65;
  localparam logic [7:0] OP_TCOMP_GIM = 8'h66;
  // opcode encodings, mask test
  localparam logic [7:0] OP_TMASK_RR = 8'h72;
  localparam logic [7:0] OP_TMASK_RIR = 8'h73;
  localparam logic [7:0] OP_TMASK_GG = 8'h74;
  localparam logic [7:0] OP_TMASK_GIR = 8'h75;
  localparam logic [7:0] OP_TMASK_GIM = 8'h76;
  // opcode encodings, exclusive-or
  localparam logic [7:0] OP_XOR_RR = 8'hB2;
  localparam logic [7:0] OP_XOR_RIR = 8'hB3;
  localparam logic [7:0] OP_XOR_GG = 8'hB4;
  localparam logic [7:0] OP_XOR_GIR = 8'hB5;
  localparam logic [7:0] OP_XOR_GIM = 8'hB6;
  // instruction lengths and cycle counts
  localparam logic [1:0] LEN_SHORT = 2'h2;
  localparam logic [1:0] LEN_LONG = 2'h3;
  localparam logic [2:0] CYC_FAST = 3'h4;
  localparam logic [2:0] CYC_SLOW = 3'h6;
  // flag bit positions inside the flag nibble {c,z,s,v}
  localparam int FLAG_C = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_S = 1;
  localparam int FLAG_V = 0;
  localparam int SIGN_BIT = 7;
  // reset values
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [1:0] LEN_RST = 2'h0;
  localparam logic [2:0] CYC_RST = 3'h0;
  // operation class
  typedef enum logic [1:0] {
    LTX_OP_NONE = 2'b00,
    LTX_OP_TCOMP = 2'b01,
    LTX_OP_TMASK = 2'b10,
    LTX_OP_XOR = 2'b11
  } ltx_op_t;
  // addressing form
  typedef enum logic [2:0] {
    LTX_AM_RR = 3'b000,
    LTX_AM_RIR = 3'b001,
    LTX_AM_GG = 3'b010,
    LTX_AM_GIR = 3'b011,
    LTX_AM_GIM = 3'b100
  } ltx_am_t;
endpackage

// *** testbench/ltx_alu_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h seen %h", nm, e, g); end end
module ltx_alu_tb_top;
  import ltx_pkg::*;
  logic core_clk = 0, rst = 1, issue = 0;
  logic [7:0] opcode = 0, byte2 = 0, byte3 = 0, dst_val = 0, src_val = 0;
  logic [3:0] flags_in = 0;
  logic done, hit, wr_en;
  logic [7:0] result, dst_addr, src_addr;
  logic [3:0] flags_out;
  logic [1:0] len;
  logic [2:0] cycles;
  logic [15:0] write_count, n_xor = 0;
  logic [34:0] q[$]; // expected {hit,wr,res,flags,len,cyc,dst,src}
  logic [34:0] e;
  logic [7:0] h_res = 0, h_dst = 0, h_src = 0; // outputs held since last hit
  logic [7:0] x_addr = 0, x_val = 0; // last xor write-back expected
  logic [3:0] h_fl = 0;
  logic [1:0] h_len = 0;
  logic [2:0] h_cyc = 0;
  int n_mismatch = 0, samples_checked = 0, ticks = 0, i;
  integer seed = 50391;
  logic [31:0] r;
  logic [3:0] hi;
  always #5 core_clk = ~core_clk;
  ltx_alu dut (.core_clk(core_clk), .rst(rst), .issue(issue), .opcode(opcode), .byte2(byte2),
    .byte3(byte3), .dst_val(dst_val), .src_val(src_val), .flags_in(flags_in), .done(done), .hit(hit),
    .result(result), .wr_en(wr_en), .dst_addr(dst_addr), .src_addr(src_addr), .flags_out(flags_out),
    .len(len), .cycles(cycles));
  ltx_regfile_model partner (.core_clk(core_clk), .rst(rst), .wr_en(wr_en), .dst_addr(dst_addr),
    .result(result), .write_count(write_count));
  // drive one instruction at the falling edge and note what must come back
  task automatic send(input logic [7:0] op, b2, b3, d, s, input logic [3:0] f);
    logic [7:0] rs;
    logic [3:0] lo;
    logic ok;
    lo = op[3:0];
    ok = (op[7:4] == 4'h6 || op[7:4] == 4'h7 || op[7:4] == 4'hB) && lo >= 4'h2 && lo <= 4'h6;
    rs = op[7:4] == 4'h6 ? (~d & s) : op[7:4] == 4'h7 ? (d & s) : (d ^ s);
    if (ok) begin
      h_res = rs;
      h_fl = {f[3], rs == 8'h00, rs[7], 1'b0};
      h_len = lo < 4'h4 ? 2'h2 : 2'h3;
      h_cyc = lo == 4'h2 ? 3'h4 : 3'h6;
      h_dst = lo < 4'h4 ? {4'h0, b2[7:4]} : lo == 4'h6 ? b2 : b3;
      h_src = lo < 4'h4 ? {4'h0, b2[3:0]} : lo == 4'h6 ? b3 : b2;
      if (op[7:4] == 4'hB) begin
        n_xor++;
        x_addr = h_dst;
        x_val = rs;
      end
    end
    q.push_back({ok, ok && op[7:4] == 4'hB, h_res, h_fl, h_len, h_cyc, h_dst, h_src});
    @(negedge core_clk);
    {opcode, byte2, byte3, dst_val, src_val, flags_in, issue} = {op, b2, b3, d, s, f, 1'b1};
  endtask
  // monitor: each completion strobe retires the oldest note
  always @(posedge core_clk) begin
    #1;
    if (rst === 1'b0 && done === 1'b1) begin
      if (q.size() == 0) begin
        `CHK("stray done", 1'b0, 1'b1)
      end else begin
        e = q.pop_front();
        `CHK("strobes", e[34:33], {hit, wr_en})
        `CHK("result", e[32:25], result)
        `CHK("flags", e[24:21], flags_out)
        `CHK("len cyc", e[20:16], {len, cycles})
        `CHK("addrs", e[15:0], {dst_addr, src_addr})
      end
    end
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // cycle ceiling: the whole run needs well under 300 cycles
  always @(posedge core_clk) begin
    ticks++;
    if (ticks >= 2000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    repeat (2) @(negedge core_clk);
    rst = 0;
    `CHK("reset outs", 36'h0, {done, hit, wr_en, result, dst_addr, src_addr, flags_out, len, cycles})
    $display("test reset done");
    // worked examples: zero hit on complement test, nonzero hit on mask test
    send(8'h62, 8'h01, 8'h00, 8'hC7, 8'h02, 4'h0);
    send(8'h72, 8'h01, 8'h00, 8'hC7, 8'h02, 4'hF);
    send(8'hB2, 8'h01, 8'h00, 8'hC7, 8'h02, 4'h8);
    send(8'h76, 8'h00, 8'h54, 8'h2B, 8'h54, 4'h8);
    send(8'hB4, 8'h02, 8'h00, 8'h2B, 8'h2B, 4'h7); // zero result
    $display("test examples done");
    // all fifteen opcodes back to back, unknown ones mixed in
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      hi = (i / 5) % 3 == 0 ? 4'h6 : (i / 5) % 3 == 1 ? 4'h7 : 4'hB;
      if (i % 7 == 6) send(r[31:24], r[7:0], r[15:8], r[23:16], r[15:8], r[3:0]);
      else send({hi, 4'(2 + i % 5)}, r[7:0], r[15:8], r[23:16], i % 5 == 4 ? r[15:8] : r[31:24], r[27:24]);
    end
    @(negedge core_clk);
    issue = 0;
    repeat (3) @(negedge core_clk);
    `CHK("pending", 0, q.size())
    `CHK("writes", n_xor, write_count)
    `CHK("wb data", x_val, partner.mem_reg[x_addr])
    $display("test sweep done");
    test_done;
  end
endmodule // ltx_alu_tb_top
`default_nettype wire

// *** testbench/ltx_regfile_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// register-file stand-in: takes the write-backs of the logic unit
module ltx_regfile_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] dst_addr,
  input wire logic [7:0] result,
  output logic [15:0] write_count
);
  logic [7:0] mem_reg [256]; // working and general registers
  // only flagged results land; test results must never show up here
  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_count <= 16'h0000;
    end else if (wr_en === 1'b1) begin
      mem_reg[dst_addr] <= result;
      write_count <= write_count + 16'h0001;
    end
  end
endmodule // ltx_regfile_model
`default_nettype wire
